// ===== rtl/smtdc_host.sv
// Host end: AXI4-Lite registers, serial memory master, transmit-off driver
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module smtdc_host #(
  parameter int unsigned TXOFF_GAP_CYC = smtdc_pkg::TXOFF_GAP_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // AXI4-Lite slave
  input  wire logic [smtdc_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [smtdc_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Link
  smtdc_link_if.host                         link
);
  import smtdc_pkg::*;

  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} smtdc_host_state_type;

  smtdc_host_state_type state;
  smtdc_host_state_type stepKind;
  logic                  awTaken;
  logic                  wTaken;
  logic [AXI_ADDR_W-1:0] wrAddr;
  logic [31:0]           wrData;
  logic                  wrLane0;
  logic                  doWrite;
  logic [31:0]           statusWord;
  logic                  assertReq;
  logic                  floatReq;
  logic                  pinHigh;
  logic [31:0]           gapCnt;
  logic [1:0]            sdaSync;
  logic [1:0]            faultSync;
  logic [1:0]            losSync;
  logic                  busy;
  logic                  nack;
  logic                  cmdRead;
  logic                  cmdDiag;
  logic [7:0]            cmdOffset;
  logic [7:0]            cmdData;
  logic [7:0]            rxData;
  logic [7:0]            rxShift;
  logic [7:0]            txByte;
  logic [7:0]            stepByte;
  logic [7:0]            devAddr;
  logic [2:0]            step;
  logic [1:0]            quarter;
  logic [3:0]            bitIdx;
  logic [7:0]            divCnt;
  logic                  tick;
  logic                  sclOut;
  logic                  sdaLow;

  // AXI4-Lite write channel; address and data in either order
  assign awready = !awTaken && !bvalid;
  assign wready  = !wTaken && !bvalid;
  assign doWrite = awTaken && wTaken && !bvalid;
  assign bresp   = AXI_OKAY;
  assign rresp   = AXI_OKAY;
  assign arready = !rvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awTaken <= 1'b0;
      wTaken  <= 1'b0;
      wrAddr  <= '0;
      wrData  <= 32'h0;
      wrLane0 <= 1'b0;
      bvalid  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awTaken <= 1'b1;
        wrAddr  <= awaddr;
      end
      if (wvalid && wready) begin
        wTaken  <= 1'b1;
        wrData  <= wdata;
        wrLane0 <= wstrb[0];
      end
      if (doWrite) begin
        awTaken <= 1'b0;
        wTaken  <= 1'b0;
        bvalid  <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    statusWord = 32'h0;
    statusWord[STS_BUSY_BIT] = busy;
    statusWord[STS_NACK_BIT] = nack;
    statusWord[STS_RDATA_LSB +: 8] = rxData;
    statusWord[STS_PIN_BIT]   = pinHigh;
    statusWord[STS_PEND_BIT]  = assertReq && !pinHigh;
    statusWord[STS_FAULT_BIT] = faultSync[1];
    statusWord[STS_LOS_BIT]   = losSync[1];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      unique case (araddr)
        REG_STATUS: rdata <= statusWord;
        REG_TXCTL:  rdata <= {30'h0, floatReq, assertReq};
        default:    rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdaSync   <= 2'h3;
      faultSync <= 2'h0;
      losSync   <= 2'h0;
    end else begin
      sdaSync   <= {sdaSync[0], link.sda};
      faultSync <= {faultSync[0], link.txFault};
      losSync   <= {losSync[0], link.receiveSignalLost};
    end
  end

  // Transmit-off pin; starts undriven so the module stays dark
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      assertReq <= 1'b0;
      floatReq  <= 1'b1;
    end else if (doWrite && wrLane0 && wrAddr == REG_TXCTL) begin
      assertReq <= wrData[TXC_ASSERT_BIT];
      floatReq  <= wrData[TXC_FLOAT_BIT];
    end
  end

  // Early assertion waits for the gap instead of being dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinHigh <= 1'b0;
      gapCnt  <= 32'h0;
    end else begin
      if (gapCnt != 32'h0) begin
        gapCnt <= gapCnt - 32'h1;
      end
      if (assertReq && !pinHigh && gapCnt == 32'h0) begin
        pinHigh <= 1'b1;
        gapCnt  <= TXOFF_GAP_CYC - 32'h1; // R4
      end else if (!assertReq) begin
        pinHigh <= 1'b0; // R2
      end
    end
  end

  assign link.txOffOut = pinHigh;
  assign link.txOffOe  = !floatReq;

  // Transfer script: write S,dev,off,data,P; read S,dev,off,S,dev+r,rx,P
  assign devAddr = cmdDiag ? DIAG_DEV_ADDR : ID_DEV_ADDR;
  always_comb begin
    stepKind = MS_BYTE;
    stepByte = devAddr;
    unique case (step)
      3'h0: stepKind = MS_START;
      3'h1: stepByte = devAddr;
      3'h2: stepByte = cmdOffset;
      3'h3: begin
        if (cmdRead) stepKind = MS_START;
        else stepByte = cmdData;
      end
      3'h4: begin
        if (cmdRead) stepByte = devAddr | 8'h01;
        else stepKind = MS_STOP;
      end
      3'h5: stepByte = 8'hff;
      default: stepKind = MS_STOP;
    endcase
  end

  assign tick = (state != MS_IDLE) && (divCnt == 8'h00);

  always_ff @(posedge clk) begin
    if (sys_rst || state == MS_IDLE) begin
      divCnt <= 8'(SCL_QUARTER_CYC - 1);
    end else begin
      divCnt <= tick ? 8'(SCL_QUARTER_CYC - 1) : divCnt - 8'h01;
    end
  end

  // Serial master: four ticks per bit, start and stop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= MS_IDLE;
      busy <= 1'b0;
      nack <= 1'b0;
      cmdRead <= 1'b0;
      cmdDiag <= 1'b0;
      cmdOffset <= 8'h00;
      cmdData <= 8'h00;
      rxData <= 8'h00;
      rxShift <= 8'h00;
      txByte <= 8'h00;
      step <= 3'h0;
      quarter <= 2'h0;
      bitIdx <= 4'h0;
      sclOut <= 1'b1;
      sdaLow <= 1'b0;
    end else if (state == MS_IDLE) begin
      // A command while busy is ignored
      if (!busy && doWrite && wrLane0 && wrAddr == REG_CMD && wrData[CMD_GO_BIT]) begin
        busy      <= 1'b1;
        nack      <= 1'b0;
        step      <= 3'h0;
        cmdRead   <= wrData[CMD_READ_BIT];
        cmdDiag   <= wrData[CMD_DIAG_BIT];
        cmdOffset <= wrData[CMD_OFF_LSB +: 8];
        cmdData   <= wrData[CMD_DATA_LSB +: 8];
      end else if (busy) begin
        state   <= stepKind;
        txByte  <= stepByte;
        quarter <= 2'h0;
        bitIdx  <= 4'h0;
      end
    end else if (tick) begin
      quarter <= quarter + 2'h1;
      unique case (quarter)
        2'h0: begin
          sclOut <= 1'b0;
          if (state == MS_START) sdaLow <= 1'b0;
          else if (state == MS_STOP) sdaLow <= 1'b1;
          else sdaLow <= (bitIdx < BYTE_BITS) && !txByte[7];
        end
        2'h1: sclOut <= 1'b1;
        2'h2: begin
          if (state == MS_START) sdaLow <= 1'b1;
          else if (state == MS_STOP) sdaLow <= 1'b0;
          else if (bitIdx < BYTE_BITS) rxShift <= {rxShift[6:0], sdaSync[1]};
          else if (step != 3'h5 && sdaSync[1]) nack <= 1'b1;
        end
        2'h3: begin
          if (state == MS_STOP) begin
            state <= MS_IDLE;
            busy  <= 1'b0;
          end else begin
            sclOut <= 1'b0;
            txByte <= {txByte[6:0], 1'b1};
            bitIdx <= bitIdx + 4'h1;
            if (state == MS_START || bitIdx == BYTE_BITS) begin
              state <= MS_IDLE;
              step  <= step + 3'h1;
              if (step == 3'h5) rxData <= rxShift;
              if (nack) step <= cmdRead ? RD_STOP_STEP : WR_STOP_STEP;
            end
          end
        end
      endcase
    end
  end

  assign link.scl       = sclOut;
  assign link.hostSdaOe = sdaLow;
endmodule

// ===== rtl/smtdc_pkg.sv
// Shared constants for the transceiver management link and its host
package smtdc_pkg;
  // Clock and link timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SCL_PERIOD_NS   = 320;
  localparam int unsigned SCL_QUARTER_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int unsigned TXOFF_GAP_MS    = 10;
  localparam int unsigned NS_PER_MS       = 1000000;
  localparam int unsigned TXOFF_GAP_CYC   = TXOFF_GAP_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Serial device addresses, 8-bit form with write bit clear
  localparam logic [7:0] ID_DEV_ADDR   = 8'ha0;
  localparam logic [7:0] DIAG_DEV_ADDR = 8'ha2;
  localparam logic [7:0] TEST_DEV_ADDR = 8'hb0;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  // Identification page; value is arbitrary
  localparam logic [7:0] ID_IDENT_OFFSET = 8'h00;
  localparam logic [7:0] ID_IDENT_VALUE  = 8'h5a;
  // Diagnostics page: monitors in order temp, vcc, bias, tx power, rx power
  localparam int unsigned MON_COUNT  = 5;
  localparam int unsigned MON_W      = 16;
  localparam logic [7:0]  MON_FIRST  = 8'h60;
  localparam logic [7:0]  MON_LAST   = 8'h69;
  localparam logic [7:0]  TX_CTRL_STATUS_OFFSET = 8'h6e;
  localparam int unsigned CS_OFF_STATE_BIT = 7;
  localparam int unsigned CS_SOFT_OFF_BIT  = 6;
  localparam int unsigned CS_FAULT_BIT     = 2;
  localparam int unsigned CS_LOS_BIT       = 1;
  // Host register map over AXI4-Lite
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXCTL  = 8'h08;
  localparam int unsigned CMD_GO_BIT   = 0;
  localparam int unsigned CMD_READ_BIT = 1;
  localparam int unsigned CMD_DIAG_BIT = 2;
  localparam int unsigned CMD_OFF_LSB  = 8;
  localparam int unsigned CMD_DATA_LSB = 16;
  localparam int unsigned STS_BUSY_BIT    = 0;
  localparam int unsigned STS_NACK_BIT    = 1;
  localparam int unsigned STS_RDATA_LSB   = 8;
  localparam int unsigned STS_PIN_BIT     = 16;
  localparam int unsigned STS_PEND_BIT    = 17;
  localparam int unsigned STS_FAULT_BIT   = 18;
  localparam int unsigned STS_LOS_BIT     = 19;
  localparam int unsigned TXC_ASSERT_BIT  = 0;
  localparam int unsigned TXC_FLOAT_BIT   = 1;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  // Master transfer steps
  localparam logic [2:0] WR_STOP_STEP = 3'h4;
  localparam logic [2:0] RD_STOP_STEP = 3'h6;
endpackage

// ===== rtl/smtdc_link_if.sv
// Two-wire management link and transmit-off pins between host and module
`timescale 1ns/1ps
interface smtdc_link_if;
  logic scl;
  logic hostSdaOe;
  logic devSdaOe;
  logic sda;
  logic txOffOut;
  logic txOffOe;
  logic txOff;
  logic txFault;
  logic receiveSignalLost;
  // Open-drain data with pull-up
  assign sda = !(hostSdaOe || devSdaOe);
  // Pull-up holds the pin high while nobody drives it
  assign txOff = txOffOe ? txOffOut : 1'b1;
  modport device (input scl, sda, txOff, output devSdaOe, txFault, receiveSignalLost);
  modport host (output scl, hostSdaOe, txOffOut, txOffOe, input sda, txFault, receiveSignalLost);
endinterface

// ===== rtl/smtdc_device.sv
// Module end: serial memory slave, transmit-off and fault logic
`timescale 1ns/1ps
// Contract
// (R1) High off input disables laser, low enables
// (R2) Cycling off input clears fault, recovers module
// (R3) Undriven off input counts as asserted
// (R4) Host spaces off assertions by interval
// (R5) Soft off bit writable in control byte
// (R6) Off state readable in control byte
// (R7) Pin off OR soft off disables laser
// (R8) Identification page answers at first address
// (R9) Diagnostics page answers at second address
// (R10) Test address reserved, not for host
// (R11) Serial memory protocol: addressing, reads, writes
// (R12) Diagnostics page shows live monitor values
// (R13) Off and signal-loss flags mirrored readable
// (R14) Fault flag in control byte
// (R15) Signal-loss flag in control byte
// (R16) Fault latches; cleared only by off toggle
// (R17) Off status bit follows pin level
// (R18) Writes to id and monitor bytes ignored
module smtdc_device (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Link
  smtdc_link_if.device                    link,
  // Module side
  input  wire logic [smtdc_pkg::MON_W-1:0] monValue [smtdc_pkg::MON_COUNT],
  input  wire logic                       laserFault,
  input  wire logic                       signalLost,
  output logic                            laserEnable
);
  import smtdc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEVACK, ST_PTR, ST_PTRACK, ST_WR, ST_WRACK, ST_RD, ST_RDACK
  } smtdc_dev_state_type;

  smtdc_dev_state_type state;
  logic [1:0]       sclSync;
  logic [1:0]       sdaSync;
  logic [1:0]       offSync;
  logic             sclPrev;
  logic             sdaPrev;
  logic             offPrev;
  logic [3:0]       bitCnt;
  logic [7:0]       shiftReg;
  logic [7:0]       rdByte;
  logic [7:0]       ptr;
  logic             sdaLow;
  logic             isRead;
  logic             diagPage;
  logic             softOff;
  logic             faultLatch;
  logic             losReg;
  logic [MON_W-1:0] monSnap [MON_COUNT];
  logic [7:0]       diagMem [0:255];
  logic [7:0]       byteAtPtr;
  logic [7:0]       statusByte;
  logic [2:0]       monIdx;
  logic             sclRise;
  logic             sclFall;
  logic             startCond;
  logic             stopCond;
  logic             byteDone;
  logic             inMon;
  logic             memWrite;
  logic             ctrlWrite;
  logic             offRise;

  // Pins from the host are synchronised before any use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      offSync <= 2'h3; // R3
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      offPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], link.scl};
      sdaSync <= {sdaSync[0], link.sda};
      offSync <= {offSync[0], link.txOff};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      offPrev <= offSync[1];
    end
  end

  assign sclRise   = sclSync[1] && !sclPrev;
  assign sclFall   = !sclSync[1] && sclPrev;
  assign startCond = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1]; // R11
  assign stopCond  = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1]; // R11
  assign offRise   = offSync[1] && !offPrev;
  assign byteDone  = sclFall && (bitCnt == BYTE_BITS);
  assign inMon     = (ptr >= MON_FIRST) && (ptr <= MON_LAST);
  assign ctrlWrite = byteDone && (state == ST_WR) && diagPage && (ptr == TX_CTRL_STATUS_OFFSET);
  // Identification page and live monitors never take writes
  assign memWrite  = byteDone && (state == ST_WR) && diagPage && !inMon // R18
                     && (ptr != TX_CTRL_STATUS_OFFSET);

  always_comb begin
    statusByte = 8'h00;
    statusByte[CS_OFF_STATE_BIT] = offSync[1]; // R6 R13 R17
    statusByte[CS_SOFT_OFF_BIT]  = softOff;    // R5
    statusByte[CS_FAULT_BIT]     = faultLatch; // R14
    statusByte[CS_LOS_BIT]       = losReg;     // R13 R15
  end

  always_comb begin
    monIdx = 3'((ptr - MON_FIRST) >> 1);
    byteAtPtr = 8'h00;
    if (!diagPage) begin
      byteAtPtr = (ptr == ID_IDENT_OFFSET) ? ID_IDENT_VALUE : 8'h00; // R8
    end else if (inMon) begin
      // Most significant byte at the even offset
      byteAtPtr = ptr[0] ? monSnap[monIdx][7:0] : monSnap[monIdx][15:8]; // R12
    end else if (ptr == TX_CTRL_STATUS_OFFSET) begin
      byteAtPtr = statusByte;
    end else begin
      byteAtPtr = diagMem[ptr]; // R9
    end
  end

  // Serial memory slave
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      rdByte   <= 8'h00;
      ptr      <= 8'h00;
      sdaLow   <= 1'b0;
      isRead   <= 1'b0;
      diagPage <= 1'b0;
    end else if (startCond) begin
      state  <= ST_DEV;
      bitCnt <= 4'h0;
      sdaLow <= 1'b0;
    end else if (stopCond) begin
      state  <= ST_IDLE;
      sdaLow <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_DEV, ST_PTR, ST_WR: begin
          if (sclRise && bitCnt != BYTE_BITS) begin
            shiftReg <= {shiftReg[6:0], sdaSync[1]};
            bitCnt   <= bitCnt + 4'h1;
          end else if (byteDone) begin
            bitCnt <= 4'h0;
            sdaLow <= 1'b1;
            if (state == ST_DEV) begin
              // Test address and strangers get no acknowledge
              if (shiftReg[7:1] == ID_DEV_ADDR[7:1] || shiftReg[7:1] == DIAG_DEV_ADDR[7:1]) begin // R8 R9 R10
                state    <= ST_DEVACK;
                diagPage <= (shiftReg[7:1] == DIAG_DEV_ADDR[7:1]);
                isRead   <= shiftReg[0];
              end else begin
                state  <= ST_IDLE;
                sdaLow <= 1'b0;
              end
            end else if (state == ST_PTR) begin
              ptr   <= shiftReg; // R11
              state <= ST_PTRACK;
            end else begin
              ptr   <= ptr + 8'h01;
              state <= ST_WRACK;
            end
          end
        end
        ST_DEVACK, ST_PTRACK, ST_WRACK: begin
          if (sclFall) begin
            sdaLow <= 1'b0;
            if (state == ST_DEVACK && isRead) begin
              state  <= ST_RD;
              rdByte <= byteAtPtr;
              sdaLow <= !byteAtPtr[7];
            end else begin
              state <= (state == ST_DEVACK) ? ST_PTR : ST_WR;
            end
          end
        end
        ST_RD: begin
          if (sclFall) begin
            if (bitCnt == LAST_BIT) begin
              sdaLow <= 1'b0;
              state  <= ST_RDACK;
              ptr    <= ptr + 8'h01;
            end else begin
              rdByte <= {rdByte[6:0], 1'b0};
              sdaLow <= !rdByte[6];
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        ST_RDACK: begin
          if (sclRise) begin
            shiftReg[0] <= sdaSync[1];
          end else if (sclFall) begin
            if (shiftReg[0]) begin
              state <= ST_IDLE;
            end else begin
              state  <= ST_RD;
              bitCnt <= 4'h0;
              rdByte <= byteAtPtr;
              sdaLow <= !byteAtPtr[7];
            end
          end
        end
      endcase
    end
  end

  // Snapshot keeps both halves of a monitor word coherent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      monSnap <= '{default: '0};
    end else if (state == ST_DEV && byteDone) begin
      monSnap <= monValue; // R12
    end
  end

  // User bytes of the diagnostics page, no reset needed
  always_ff @(posedge clk) begin
    if (memWrite) begin
      diagMem[ptr] <= shiftReg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      softOff <= 1'b0;
    end else if (ctrlWrite) begin
      softOff <= shiftReg[CS_SOFT_OFF_BIT]; // R5
    end
  end

  // New fault wins over a clearing toggle in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultLatch <= 1'b0;
    end else if (laserFault) begin
      faultLatch <= 1'b1; // R16
    end else if (offRise) begin
      faultLatch <= 1'b0; // R2 R16
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      losReg      <= 1'b0;
      laserEnable <= 1'b0;
    end else begin
      losReg      <= signalLost;
      laserEnable <= !(offSync[1] || softOff || faultLatch); // R1 R7
    end
  end

  assign link.devSdaOe          = sdaLow;
  assign link.txFault           = faultLatch;
  assign link.receiveSignalLost = losReg;
endmodule

// ===== verification/smtdc_link_chk.sv
// Assertions on the link between host and module ends
`timescale 1ns/1ps
module smtdc_link_chk #(
  parameter int unsigned TXOFF_GAP_CYC = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  input wire logic scl,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic sda,
  input wire logic txOffOut,
  input wire logic txOffOe,
  input wire logic txOff,
  input wire logic txFault,
  input wire logic receiveSignalLost
);
  logic        pinHigh;
  logic [31:0] gapCnt;
  assign pinHigh = txOffOe && txOffOut;
  // Cycles since the pin was last driven high
  always_ff @(posedge clk) begin
    if (sys_rst) gapCnt <= TXOFF_GAP_CYC;
    else if ($rose(pinHigh)) gapCnt <= 32'h1;
    else if (gapCnt < TXOFF_GAP_CYC) gapCnt <= gapCnt + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  reset_idle_a: assert property (
    disable iff (1'h0) sys_rst |=> scl && !hostSdaOe && !devSdaOe && !txOffOe && !txFault)
    else $error("link not idle in reset");
  dev_stable_a: assert property (
    scl && $past(scl) |-> $stable(devSdaOe)) else $error("module data moved, clock high");
  ack_low_a: assert property (
    $rose(devSdaOe) |-> !scl [*8]) else $error("module pulled data late");
  clk_high_a: assert property (
    $rose(scl) |-> scl [*8]) else $error("clock high too short");
  clk_low_a: assert property (
    $fell(scl) |-> !scl [*8]) else $error("clock low too short");
  start_hold_a: assert property (
    $rose(hostSdaOe) && $past(scl) && scl |-> scl [*4]) else $error("bad start");
  assert_gap_a: assert property (
    $rose(pinHigh) |-> gapCnt >= TXOFF_GAP_CYC - 1) else $error("pin reasserted early");
  fault_clear_a: assert property (
    $fell(txFault) |-> txOff) else $error("fault cleared without toggle");
  cover property ($rose(devSdaOe));
  cover property ($fell(txFault));
  cover property ($rose(pinHigh));
  cover property ($rose(receiveSignalLost));
  cover property (scl && $fell(sda));
endmodule

// ===== verification/sfp_management_tx_disable_ctrl_tb.sv
// Bench for the host and module ends joined by the link
`timescale 1ns/1ps
module sfp_management_tx_disable_ctrl_tb;
  import smtdc_pkg::*;
  localparam int unsigned GAP = 200;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        laserFault = 1'h0;
  logic        signalLost = 1'h0;
  logic [15:0] mon [MON_COUNT];
  logic        awready, wready, bvalid, arready, rvalid, laserEnable;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fails = 0;
  int          checks_done = 0;
  always #5 clk = ~clk;
  smtdc_link_if link();
  smtdc_device u_smtdc_device (.clk(clk), .sys_rst(sys_rst), .link(link), .monValue(mon),
    .laserFault(laserFault), .signalLost(signalLost), .laserEnable(laserEnable));
  smtdc_host #(.TXOFF_GAP_CYC(GAP)) u_smtdc_host (
    .clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  smtdc_link_chk #(.TXOFF_GAP_CYC(GAP)) u_smtdc_link_chk (
    .clk(clk), .sys_rst(sys_rst), .scl(link.scl), .hostSdaOe(link.hostSdaOe),
    .devSdaOe(link.devSdaOe), .sda(link.sda), .txOffOut(link.txOffOut),
    .txOffOe(link.txOffOe), .txOff(link.txOff), .txFault(link.txFault),
    .receiveSignalLost(link.receiveSignalLost));
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang;
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // Handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ah = awready;
      wh = wready;
      bh = bvalid;
      @(posedge clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      n++;
    end while (!bh && n < 99);
    bready <= 1'h0;
    if (!bh) hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ah, rh;
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ah = arready;
      rh = rvalid;
      d = rdata;
      @(posedge clk);
      if (ah) arvalid <= 1'h0;
      n++;
    end while (!rh && n < 99);
    rready <= 1'h0;
    if (!rh) hang();
  endtask
  // One serial byte through the command register, then poll until idle
  task automatic op(input logic r, g, input logic [7:0] o, v, output logic [7:0] q);
    logic [31:0] s;
    int n = 0;
    wr(REG_CMD, {8'h00, v, o, 5'h00, g, r, 1'h1});
    do begin
      rd(REG_STATUS, s);
      n++;
    end while (s[STS_BUSY_BIT] !== 1'h0 && n < 2000);
    if (n >= 2000) hang();
    chk(s[STS_NACK_BIT], 1'h0);
    chk({bresp, rresp}, 4'h0);
    q = s[15:8];
  endtask
  function automatic logic [7:0] cs(input logic p, s, f, l);
    return {p, s, 3'h0, f, l, 1'h0};
  endfunction
  task automatic rd6e(input logic [7:0] e);
    logic [7:0] q;
    op(1'h1, 1'h1, TX_CTRL_STATUS_OFFSET, 8'h00, q);
    chk(q, e);
  endtask
  task automatic le(input logic e);
    int n = 0;
    while (laserEnable !== e && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(laserEnable, e);
  endtask
  initial begin
    logic [31:0] s;
    logic [31:0] r;
    logic [7:0]  q;
    void'($urandom(60217));
    foreach (mon[i]) mon[i] <= 16'($urandom);
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    rd(REG_TXCTL, s);
    chk(s, 32'h2);
    chk(laserEnable, 1'h0);
    rd6e(cs(1'h1, 1'h0, 1'h0, 1'h0));
    wr(REG_TXCTL, 32'h0);
    le(1'h1);
    $display("reset test ends");
    op(1'h1, 1'h0, ID_IDENT_OFFSET, 8'h00, q);
    chk(q, ID_IDENT_VALUE);
    for (int i = 0; i < 10; i++) begin
      op(1'h1, 1'h1, MON_FIRST + 8'(i), 8'h00, q);
      r = mon[i / 2];
      chk(q, i % 2 ? r[7:0] : r[15:8]);
    end
    op(1'h0, 1'h1, MON_FIRST, ~mon[0][15:8], q);
    op(1'h1, 1'h1, MON_FIRST, 8'h00, q);
    chk(q, mon[0][15:8]);
    $display("page test ends");
    // Corner bytes first, then random ones
    for (int k = 0; k < 4; k++) begin
      r = k == 0 ? 32'h40 : k == 1 ? 32'hbf : $urandom;
      op(1'h0, 1'h1, TX_CTRL_STATUS_OFFSET, r[7:0], q);
      le(!r[6]);
      rd6e(cs(1'h0, r[6], 1'h0, 1'h0));
    end
    op(1'h0, 1'h1, TX_CTRL_STATUS_OFFSET, 8'h00, q);
    le(1'h1);
    signalLost <= 1'h1;
    rd6e(cs(1'h0, 1'h0, 1'h0, 1'h1));
    rd(REG_STATUS, s);
    chk(s[STS_LOS_BIT], 1'h1);
    signalLost <= 1'h0;
    $display("soft-off test ends");
    wr(REG_TXCTL, 32'h1);
    le(1'h0);
    wr(REG_TXCTL, 32'h0);
    wr(REG_TXCTL, 32'h1);
    rd(REG_STATUS, s);
    chk(s[STS_PEND_BIT], 1'h1);
    le(1'h1);
    le(1'h0);
    rd6e(cs(1'h1, 1'h0, 1'h0, 1'h0));
    wr(REG_TXCTL, 32'h0);
    le(1'h1);
    laserFault <= 1'h1;
    @(posedge clk);
    laserFault <= 1'h0;
    le(1'h0);
    rd(REG_STATUS, s);
    chk(s[STS_FAULT_BIT], 1'h1);
    rd6e(cs(1'h0, 1'h0, 1'h1, 1'h0));
    wr(REG_TXCTL, 32'h1);
    rd(REG_STATUS, s);
    chk(s[STS_PIN_BIT], 1'h1);
    wr(REG_TXCTL, 32'h0);
    le(1'h1);
    chk(link.txFault, 1'h0);
    $display("pin test ends");
    complete_run();
  end
endmodule
